/* File: core/apiag_core.sv */
// aux pointer indirect address generator: pointer file, address and update
`timescale 1ns/1ns
`include "apiag_cfg.svh"
module apiag_core #(
   parameter int ADDR_W  = `APIAG_ADDR_W,
   parameter int DATA_W  = `APIAG_DATA_W,
   parameter int NUM_PTR = `APIAG_NUM_PTR
) (
   // clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_rstn,
   // decoded request
   input  wire logic                        i_req,
   input  wire logic [`APIAG_PTR_SEL_W-1:0] i_ptr_sel,
   input  wire apiag_pkg::apiag_op_e        i_op,
   input  wire apiag_pkg::apiag_space_e     i_space,
   input  wire logic                        i_wide,
   input  wire logic [DATA_W-1:0]           i_k16,
   input  wire logic [`APIAG_K3_W-1:0]      i_k3,
   // mode and index sources
   input  wire logic                        i_mode_sel,
   input  wire logic                        i_compat,
   input  wire logic [DATA_W-1:0]           i_temp_zero,
   input  wire logic [DATA_W-1:0]           i_temp_one,
   // pointer load from the core
   input  wire logic                        i_ld,
   input  wire logic [`APIAG_PTR_SEL_W-1:0] i_ld_sel,
   input  wire logic [ADDR_W-1:0]           i_ld_val,
   // address to memory stage
   output logic                             o_addr_vld,
   output logic [ADDR_W-1:0]                o_addr,
   output logic                             o_illegal,
   output logic [ADDR_W-1:0]                o_ptr_sel_val
);
   logic [ADDR_W-1:0] ptr_q [NUM_PTR];
   logic [ADDR_W-1:0] ptr_d [NUM_PTR];
   logic              addr_vld_q, addr_vld_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic              illegal_q, illegal_d;
   logic [ADDR_W-1:0] sel_val_q, sel_val_d;
   logic              legal;
   logic [ADDR_W-1:0] base;
   logic [ADDR_W-1:0] idx;
   logic [ADDR_W-1:0] step;
   logic [ADDR_W-1:0] new_ptr;
   logic              upd;

   function automatic logic [ADDR_W-1:0] sext(input logic [DATA_W-1:0] v);
      sext = {{(ADDR_W-DATA_W){v[DATA_W-1]}}, v};
   endfunction : sext

   apiag_legal u_legal (
      .i_mode_sel (i_mode_sel),
      .i_op       (i_op),
      .i_space    (i_space),
      .o_legal    (legal)
   );

   always_comb begin
      base    = ptr_q[i_ptr_sel];
      // index is aux zero or sign-extended temp zero
      idx     = i_compat ? ptr_q[`APIAG_IDX_PTR] : sext(i_temp_zero);
      step    = i_wide ? `APIAG_STEP_TWO : `APIAG_STEP_ONE;
      addr_d  = base;
      new_ptr = base;
      upd     = 1'b0;
      // all sums wrap at 23 bits
      unique case (i_op)
         apiag_pkg::apiag_op_plain: ;
         apiag_pkg::apiag_op_post_inc: begin new_ptr = base + step; upd = 1'b1; end
         apiag_pkg::apiag_op_post_dec: begin new_ptr = base - step; upd = 1'b1; end
         apiag_pkg::apiag_op_post_add_idx: begin new_ptr = base + idx; upd = 1'b1; end
         apiag_pkg::apiag_op_post_sub_idx: begin new_ptr = base - idx; upd = 1'b1; end
         apiag_pkg::apiag_op_post_add_t1: begin
            new_ptr = base + sext(i_temp_one);
            upd     = 1'b1;
         end
         apiag_pkg::apiag_op_post_sub_t1: begin
            new_ptr = base - sext(i_temp_one);
            upd     = 1'b1;
         end
         apiag_pkg::apiag_op_base_idx: addr_d = base + idx;
         apiag_pkg::apiag_op_base_t1: addr_d = base + sext(i_temp_one);
         apiag_pkg::apiag_op_base_k16: addr_d = base + sext(i_k16);
         apiag_pkg::apiag_op_pre_k16: begin
            new_ptr = base + sext(i_k16);
            addr_d  = new_ptr;
            upd     = 1'b1;
         end
         apiag_pkg::apiag_op_pre_inc: begin
            new_ptr = base + step;
            addr_d  = new_ptr;
            upd     = 1'b1;
         end
         apiag_pkg::apiag_op_pre_dec: begin
            new_ptr = base - step;
            addr_d  = new_ptr;
            upd     = 1'b1;
         end
         apiag_pkg::apiag_op_short_k3:
            addr_d = base + {{(ADDR_W-`APIAG_K3_W){1'b0}}, i_k3};
         default: ;
      endcase
      addr_vld_d = i_req && legal;
      illegal_d  = i_req && !legal;
      if (!addr_vld_d) begin
         addr_d = addr_q;
      end
      sel_val_d = (addr_vld_d && upd) ? new_ptr : base;
      for (int i = 0; i < NUM_PTR; i++) begin
         ptr_d[i] = ptr_q[i];
         if (i_ld && (i_ld_sel == i[`APIAG_PTR_SEL_W-1:0])) begin
            ptr_d[i] = i_ld_val;
         end
         // pointer update wins over a same-cycle load
         if (addr_vld_d && upd && (i_ptr_sel == i[`APIAG_PTR_SEL_W-1:0])) begin
            ptr_d[i] = new_ptr;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         for (int i = 0; i < NUM_PTR; i++) begin
            ptr_q[i] <= `APIAG_PTR_RST;
         end
         addr_vld_q <= 1'b0;
         addr_q     <= `APIAG_PTR_RST;
         illegal_q  <= 1'b0;
         sel_val_q  <= `APIAG_PTR_RST;
      end else begin
         ptr_q      <= ptr_d;
         addr_vld_q <= addr_vld_d;
         addr_q     <= addr_d;
         illegal_q  <= illegal_d;
         sel_val_q  <= sel_val_d;
      end
   end

   assign o_addr_vld    = addr_vld_q;
   assign o_addr        = addr_q;
   assign o_illegal     = illegal_q;
   assign o_ptr_sel_val = sel_val_q;
endmodule : apiag_core

/* File: core/apiag_cfg.svh */
// constants and the behaviour list of the aux pointer indirect address generator
// Behaviour
// - post-increment adds 1 for 16-bit/1-bit access, 2 for 32-bit/2-bit.
// - post-decrement subtracts 1 for 16-bit/1-bit access, 2 for 32-bit/2-bit.
// - single register bit counts as 1-bit step, bit pair as 2-bit step.
// - subtract-index post-modify subtracts sign-extended index after address forms.
// - indexed base adds sign-extended index offset, pointer unchanged.
// - immediate base adds sign-extended 16-bit immediate, pointer unchanged.
// - immediate comes from instruction extension; no parallel issue allowed.
// - pre-modify immediate updates pointer first, address uses new pointer.
// - short offset zero-extends 3-bit constant 1..7 onto unchanged pointer.
// - index and short-offset forms accepted for all four access spaces.
// - 16-bit immediate forms refused for I/O space accesses.
// - mode select 0 adds pre-inc, pre-dec, temp one base; refuses short offset.
// - mode select 1 allows short offset, refuses single-step pre-inc/pre-dec.
// - add-index post-modify adds selected index after address forms.
`ifndef APIAG_CFG_SVH
`define APIAG_CFG_SVH
`define APIAG_ADDR_W    23
`define APIAG_DATA_W    16
`define APIAG_NUM_PTR   8
`define APIAG_PTR_SEL_W 3
`define APIAG_K3_W      3
`define APIAG_IDX_PTR   3'h0
`define APIAG_PTR_RST   23'h000000
`define APIAG_STEP_ONE  23'h000001
`define APIAG_STEP_TWO  23'h000002
`endif

/* File: core/apiag_pkg.sv */
// types of the aux pointer indirect address generator
package apiag_pkg;
   typedef enum logic [3:0] {
      apiag_op_plain,
      apiag_op_post_inc,
      apiag_op_post_dec,
      apiag_op_post_add_idx,
      apiag_op_post_sub_idx,
      apiag_op_post_add_t1,
      apiag_op_post_sub_t1,
      apiag_op_base_idx,
      apiag_op_base_t1,
      apiag_op_base_k16,
      apiag_op_pre_k16,
      apiag_op_pre_inc,
      apiag_op_pre_dec,
      apiag_op_short_k3
   } apiag_op_e;

   typedef enum logic [1:0] {
      apiag_sp_data,
      apiag_sp_mmr,
      apiag_sp_bit,
      apiag_sp_io
   } apiag_space_e;
endpackage : apiag_pkg

/* File: core/apiag_legal.sv */
// operand legality check against mode select bit and access space
`timescale 1ns/1ns
module apiag_legal (
   // request
   input  wire logic              i_mode_sel,
   input  wire apiag_pkg::apiag_op_e    i_op,
   input  wire apiag_pkg::apiag_space_e i_space,
   // result
   output logic                   o_legal
);
   logic uses_k16;
   logic mode_ok;

   always_comb begin
      uses_k16 = (i_op == apiag_pkg::apiag_op_base_k16) || (i_op == apiag_pkg::apiag_op_pre_k16);
      unique case (i_op)
         apiag_pkg::apiag_op_pre_inc,
         apiag_pkg::apiag_op_pre_dec,
         apiag_pkg::apiag_op_base_t1: mode_ok = !i_mode_sel;
         apiag_pkg::apiag_op_short_k3: mode_ok = i_mode_sel;
         default: mode_ok = 1'b1;
      endcase
      o_legal = mode_ok && !(uses_k16 && (i_space == apiag_pkg::apiag_sp_io));
   end
endmodule : apiag_legal

/* File: verification/apiag_chk.sv */
// port assertions of the aux pointer indirect address generator
`timescale 1ns/1ns
module apiag_chk #(
   parameter int ADDR_W = 23
) (
   // request side
   input wire logic                 i_clk,
   input wire logic                 i_rstn,
   input wire logic                 i_req,
   input wire apiag_pkg::apiag_op_e i_op,
   input wire logic                 i_wide,
   input wire logic [2:0]           i_k3,
   input wire logic                 i_mode_sel,
   // answer side
   input wire logic                 o_addr_vld,
   input wire logic [ADDR_W-1:0]    o_addr,
   input wire logic                 o_illegal,
   input wire logic [ADDR_W-1:0]    o_ptr_sel_val
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   always_ok_a:
      assert property (i_req && i_op < 4'h8 |=> o_addr_vld && !o_illegal)
      else $error("legal form not taken");
   ctl_refuse_a:
      assert property (i_req && i_mode_sel && i_op inside {4'h8, 4'hB, 4'hC} |=> o_illegal)
      else $error("control mode form not refused");
   dsp_refuse_a:
      assert property (i_req && !i_mode_sel && i_op == 4'hD |=> o_illegal && !o_addr_vld)
      else $error("short offset not refused");
   idle_quiet_a:
      assert property (!i_req |=> !o_addr_vld && !o_illegal)
      else $error("answer without request");
   addr_hold_a:
      assert property (!o_addr_vld |-> $stable(o_addr))
      else $error("address moved while idle");
   post_step_a:
      assert property (i_req && i_op == 4'h1 |=>
         o_ptr_sel_val == o_addr + ($past(i_wide) ? 23'h2 : 23'h1))
      else $error("post step wrong");
   plain_ptr_a:
      assert property (i_req && i_op == 4'h0 |=> o_addr == o_ptr_sel_val)
      else $error("plain address not pointer");
   short_off_a:
      assert property (i_req && i_mode_sel && i_op == 4'hD |=>
         o_addr == o_ptr_sel_val + $past(i_k3))
      else $error("short offset address wrong");
   cover property (i_req && i_op == 4'hA ##1 o_addr_vld);
   cover property (o_illegal ##1 o_addr_vld);
   cover property (o_addr_vld [*3]);
endmodule : apiag_chk

bind apiag_core apiag_chk #(.ADDR_W(ADDR_W)) u_chk (
   .i_clk         (i_clk),
   .i_rstn        (i_rstn),
   .i_req         (i_req),
   .i_op          (i_op),
   .i_wide        (i_wide),
   .i_k3          (i_k3),
   .i_mode_sel    (i_mode_sel),
   .o_addr_vld    (o_addr_vld),
   .o_addr        (o_addr),
   .o_illegal     (o_illegal),
   .o_ptr_sel_val (o_ptr_sel_val)
);

/* File: verification/apiag_mem_mdl.sv */
// memory stage model: counts the addresses handed to it
`timescale 1ns/1ns
module apiag_mem_mdl (
   // from the generator
   input  wire logic  i_clk,
   input  wire logic  i_addr_vld,
   // accesses seen
   output logic [31:0] o_count
);
   logic [31:0] count_q = 32'h0;
   always @(posedge i_clk)
      if (i_addr_vld === 1'b1)
         count_q <= count_q + 32'h1;
   assign o_count = count_q;
endmodule : apiag_mem_mdl

/* File: verification/test_aux_pointer_indirect_addr_gen.sv */
// random bench of the aux pointer indirect address generator
`timescale 1ns/1ns
module test_aux_pointer_indirect_addr_gen;
   logic        i_clk = 1'b0, i_rstn = 1'b0, i_req, i_wide, i_mode_sel, i_compat, i_ld;
   logic        o_addr_vld, o_illegal, e_vld = 1'b0, e_ill = 1'b0;
   logic [2:0]  i_ptr_sel, i_ld_sel, i_k3;
   logic [15:0] i_k16, i_temp_zero, i_temp_one;
   logic [22:0] i_ld_val, o_addr, o_ptr_sel_val, e_addr, e_ptr, a, n, x, p [8];
   logic [31:0] seed = 32'h76F0, mem_n;
   int          err_count = 0, n_compared = 0, cyc = 0, n_ok = 0;
   apiag_pkg::apiag_op_e    i_op;
   apiag_pkg::apiag_space_e i_space;
   apiag_core    dut (
      .i_clk         (i_clk),
      .i_rstn        (i_rstn),
      .i_req         (i_req),
      .i_ptr_sel     (i_ptr_sel),
      .i_op          (i_op),
      .i_space       (i_space),
      .i_wide        (i_wide),
      .i_k16         (i_k16),
      .i_k3          (i_k3),
      .i_mode_sel    (i_mode_sel),
      .i_compat      (i_compat),
      .i_temp_zero   (i_temp_zero),
      .i_temp_one    (i_temp_one),
      .i_ld          (i_ld),
      .i_ld_sel      (i_ld_sel),
      .i_ld_val      (i_ld_val),
      .o_addr_vld    (o_addr_vld),
      .o_addr        (o_addr),
      .o_illegal     (o_illegal),
      .o_ptr_sel_val (o_ptr_sel_val)
   );
   apiag_mem_mdl mem (.i_clk(i_clk), .i_addr_vld(o_addr_vld), .o_count(mem_n));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic [22:0] sx(input logic [15:0] v);
      return {{7{v[15]}}, v};
   endfunction : sx
   task automatic chk(input logic [22:0] got, input logic [22:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   // random request, then its expected answer; early ones walk every form
   task automatic stim(input int k);
      seed = xs(seed);
      i_req = k > 0 && k < 2000 && (k < 30 || seed[0]);
      i_ptr_sel = seed[3:1];
      i_op = apiag_pkg::apiag_op_e'(k < 30 ? k % 14 : seed[31:28] % 14);
      i_space = apiag_pkg::apiag_space_e'(seed[5:4]);
      i_wide = seed[6];
      i_mode_sel = seed[7];
      i_compat = seed[8];
      i_k3 = seed[11:9] == 3'h0 ? 3'h7 : seed[11:9];
      i_ld = seed[12];
      // one load in eight hits the selected pointer: an update must win over it
      i_ld_sel = i_ptr_sel ^ seed[15:13];
      i_ld_val = seed[16] ? 23'h7FFFFF : seed[22:0];
      seed = xs(seed);
      i_k16 = seed[15:0];
      i_temp_zero = seed[31:16];
      i_temp_one = seed[23:8];
      x = i_compat ? p[0] : sx(i_temp_zero);
      a = p[i_ptr_sel];
      n = a;
      case (i_op)
         4'h1, 4'hB: n = a + (i_wide ? 23'h2 : 23'h1);
         4'h2, 4'hC: n = a - (i_wide ? 23'h2 : 23'h1);
         4'h3: n = a + x;
         4'h4: n = a - x;
         4'h5: n = a + sx(i_temp_one);
         4'h6: n = a - sx(i_temp_one);
         4'h7: a = a + x;
         4'h8: a = a + sx(i_temp_one);
         4'h9: a = a + sx(i_k16);
         4'hA: n = a + sx(i_k16);
         4'hD: a = a + 23'(i_k3);
         default: ;
      endcase
      if (i_op inside {4'hA, 4'hB, 4'hC})
         a = n;
      e_ill = i_req && ((i_mode_sel && i_op inside {4'h8, 4'hB, 4'hC})
         || (!i_mode_sel && i_op == 4'hD) || (i_space == 2'h3 && i_op inside {4'h9, 4'hA}));
      e_vld = i_req && !e_ill;
      if (i_ld)
         p[i_ld_sel] = i_ld_val;
      if (e_vld) begin
         e_addr = a;
         e_ptr = n;
         if (!(i_op inside {4'h0, 4'h7, 4'h8, 4'h9, 4'hD}))
            p[i_ptr_sel] = n;
         n_ok++;
      end
   endtask : stim
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         test_done();
      end
   end
   initial begin
      p = '{default: 23'h0};
      stim(0);
      repeat (5) @(negedge i_clk);
      i_rstn = 1'b1;
      for (int k = 1; k <= 2000; k++) begin
         @(negedge i_clk);
         chk({21'h0, o_addr_vld, o_illegal}, {21'h0, e_vld, e_ill});
         if (e_vld)
            chk(o_addr, e_addr);
         if (e_vld)
            chk(o_ptr_sel_val, e_ptr);
         stim(k);
      end
      @(negedge i_clk);
      chk(mem_n[22:0], n_ok[22:0]);
      test_done();
   end
endmodule : test_aux_pointer_indirect_addr_gen
